// ===== inc/lsg_pkg.sv
// Constants shared by the link status and output-line register bank.
// Assumes an 8-bit register port behind the device's I2C slave logic.
package lsg_pkg;
  // Register offsets
  localparam logic [7:0] LSG_OFS_PHYS = 8'h08;
  localparam logic [7:0] LSG_OFS_ALIAS = 8'h09;
  localparam logic [7:0] LSG_OFS_CNT_LO = 8'h0A;
  localparam logic [7:0] LSG_OFS_CNT_HI = 8'h0B;
  localparam logic [7:0] LSG_OFS_STATUS = 8'h0C;
  localparam logic [7:0] LSG_OFS_GPO = 8'h0D;
  // Values after reset, and the error counter's saturation limit
  localparam logic [6:0] LSG_RST_ID = 7'h00;
  localparam logic [15:0] LSG_RST_COUNT = 16'h0000;
  localparam logic [15:0] LSG_COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] LSG_RST_GPO = 8'h55;
  localparam logic LSG_RST_FAR = 1'b0;
  // Writable bits of the output-line configuration
  localparam logic [7:0] LSG_GPO_WMASK = 8'hDD;
  // Field positions
  localparam int LSG_ID_LSB = 1;
  localparam int LSG_ST_REV_LSB = 5;
  localparam int LSG_ST_LOCK = 4;
  localparam int LSG_ST_BUILT_IN_SELF_TEST = 3;
  localparam int LSG_ST_PCLK = 2;
  localparam int LSG_ST_FAR = 1;
  localparam int LSG_ST_LINK = 0;
  localparam int LSG_GENERAL_OUTPUT_LINE_ONE_VAL = 7;
  localparam int LSG_GENERAL_OUTPUT_LINE_ONE_RMT = 6;
  localparam int LSG_GENERAL_OUTPUT_LINE_ONE_EN = 4;
  localparam int LSG_GENERAL_OUTPUT_LINE_ZERO_VAL = 3;
  localparam int LSG_GENERAL_OUTPUT_LINE_ZERO_RMT = 2;
  localparam int LSG_GENERAL_OUTPUT_LINE_ZERO_EN = 0;
  // Synchronised status pins: lock, self-test error, pixel clock, link, four cable faults
  localparam int LSG_SYNC_W = 8;
endpackage

// ===== inc/lsg_alias_if.sv
// Carrier between the register bank and the remote-target alias decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface lsg_alias_if;
  logic [6:0] alias_id;
  logic [6:0] phys_id;
  logic req;
  logic [6:0] req_addr;
  logic fwd;
  logic blocked;
  logic [6:0] fwd_addr;
  modport ctrl (output alias_id, phys_id, req, req_addr, input fwd, blocked, fwd_addr);
  modport dec (input alias_id, phys_id, req, req_addr, output fwd, blocked, fwd_addr);
endinterface
`default_nettype wire

// ===== logic/lsg_alias_dec.sv
// Remote-target alias decoder: matches incoming addresses and remaps them.
// Assumes one request pulse per I2C address phase, on the bank's clock.
`timescale 1ns/1ps
`default_nettype none
module lsg_alias_dec
  import lsg_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  lsg_alias_if.dec bus
);
  wire alias_on = (bus.alias_id != LSG_RST_ID);
  wire phys_on = (bus.phys_id != LSG_RST_ID);
  wire hit = bus.req && alias_on && (bus.req_addr == bus.alias_id);
  wire next_fwd = hit && phys_on;
  wire next_blocked = hit && !phys_on;

  always_ff @(posedge clk) begin
    if (srst) begin
      bus.fwd <= 1'b0;
      bus.blocked <= 1'b0;
      bus.fwd_addr <= LSG_RST_ID;
    end else begin
      bus.fwd <= next_fwd;
      bus.blocked <= next_blocked;
      if (next_fwd) begin
        bus.fwd_addr <= bus.phys_id;
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/lsg_regs.sv
// Link status, back-channel error counter, alias and output-line register bank.
// Assumes the I2C slave logic presents byte reads and writes as one-cycle strobes.
// Summary of operation
// - Incoming target address equal to alias field means the remote slave is addressed.
// - On alias match, forward with the programmed physical address substituted.
// - Alias field zero disables all decoding and forwarding to the remote slave.
// - Back-channel CRC errors counted in 16 bits; low byte 0x0A, high byte 0x0B.
// - Status top three bits show a fixed read-only silicon revision.
// - Status bit 3 is high while self-test sees CRC errors, else low.
// - Status bit 2 shows whether a valid pixel clock is present.
// - Far-end error bit sets on a CRC error talking to the deserializer.
// - Far-end error bit clears on link loss or CRC error reset control.
// - Status bit 0 is high when a cable link is detected.
// - Link bit reads zero on open cable, pair short, ground or battery short.
// - Enabled line, not remote, drives its local value bit (7 or 3).
// - Remote control bit (6 or 2) makes the line drive the received remote value.
// - Enable bit (4 or 0) turns the line on; zero leaves it tri-stated.
// - After reset remote and enable bits are one, value and reserved bits zero.
// - Physical address field zero blocks forwarding to the remote slave.
`timescale 1ns/1ps
`default_nettype none
module lsg_regs
  import lsg_pkg::*;
#(
  parameter logic [2:0] REVISION = 3'h5 // Arbitrary value
)(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic I2C_REQ,
  input wire logic [6:0] I2C_ADDR,
  output logic FWD_REMOTE,
  output logic FWD_BLOCKED,
  output logic [6:0] FWD_ADDR,
  input wire logic BC_CRC_ERR,
  input wire logic FAR_CRC_ERR,
  input wire logic CRC_ERR_RESET,
  input wire logic RX_LOCK,
  input wire logic BUILT_IN_SELF_TEST_CRC_ERR,
  input wire logic PCLK_DETECT,
  input wire logic LINK_PRESENT,
  input wire logic [3:0] CABLE_FAULT,
  input wire logic [1:0] REMOTE_GPO_VAL,
  output logic [1:0] GPO_OUT,
  output logic [1:0] GPO_OE
);
  logic [6:0] phys_id;
  logic [6:0] alias_id;
  logic [15:0] err_count;
  logic far_err;
  logic [7:0] gpo_cfg;
  logic [LSG_SYNC_W-1:0] sync_a;
  logic [LSG_SYNC_W-1:0] sync_b;

  // Line drive: remote value when remote control is on, otherwise the local bit
  function automatic logic line_value(input logic rmt, input logic loc, input logic rval);
    line_value = rmt ? rval : loc;
  endfunction

  // Status pins arrive from analog and other clock areas
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {CABLE_FAULT, LINK_PRESENT, PCLK_DETECT, BUILT_IN_SELF_TEST_CRC_ERR, RX_LOCK};
      sync_b <= sync_a;
    end
  end

  wire st_lock = sync_b[0];
  wire st_built_in_self_test = sync_b[1];
  wire st_pclk = sync_b[2];
  wire [3:0] fault_s = sync_b[7:4];
  wire st_link = sync_b[3] && (fault_s == 4'h0);

  // Register decode
  wire wr_phys = REG_WR && (REG_ADDR == LSG_OFS_PHYS);
  wire wr_alias = REG_WR && (REG_ADDR == LSG_OFS_ALIAS);
  wire wr_gpo = REG_WR && (REG_ADDR == LSG_OFS_GPO);

  // Counter: an error in the clearing cycle still counts, so none is lost
  wire cnt_clr = CRC_ERR_RESET;
  wire cnt_full = (err_count == LSG_COUNT_MAX);
  wire [15:0] cnt_base = cnt_clr ? LSG_RST_COUNT : err_count;
  wire [15:0] next_count = (BC_CRC_ERR && !(cnt_full && !cnt_clr)) ? 16'(cnt_base + 16'h0001) : cnt_base;

  // Far-end error: set wins over link loss and the reset control
  wire far_clr = CRC_ERR_RESET || !st_link;
  wire next_far = FAR_CRC_ERR ? 1'b1 : (far_clr ? 1'b0 : far_err);

  wire [7:0] status = {REVISION, st_lock, st_built_in_self_test, st_pclk, far_err, st_link};

  wire [7:0] next_rdata =
    (REG_ADDR == LSG_OFS_PHYS) ? {phys_id, 1'b0} :
    (REG_ADDR == LSG_OFS_ALIAS) ? {alias_id, 1'b0} :
    (REG_ADDR == LSG_OFS_CNT_LO) ? err_count[7:0] :
    (REG_ADDR == LSG_OFS_CNT_HI) ? err_count[15:8] :
    (REG_ADDR == LSG_OFS_STATUS) ? status :
    (REG_ADDR == LSG_OFS_GPO) ? gpo_cfg : 8'h00;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      phys_id <= LSG_RST_ID;
      alias_id <= LSG_RST_ID;
      gpo_cfg <= LSG_RST_GPO;
    end else begin
      if (wr_phys) begin
        phys_id <= REG_WDATA[7:LSG_ID_LSB];
      end
      if (wr_alias) begin
        alias_id <= REG_WDATA[7:LSG_ID_LSB];
      end
      if (wr_gpo) begin
        gpo_cfg <= REG_WDATA & LSG_GPO_WMASK;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      err_count <= LSG_RST_COUNT;
      far_err <= LSG_RST_FAR;
      REG_RDATA <= 8'h00;
    end else begin
      err_count <= next_count;
      far_err <= next_far;
      if (REG_RD) begin
        REG_RDATA <= next_rdata;
      end
    end
  end

  // Output lines; reserved direction means enabled lines are always outputs
  wire [1:0] next_gpo = {
    line_value(gpo_cfg[LSG_GENERAL_OUTPUT_LINE_ONE_RMT], gpo_cfg[LSG_GENERAL_OUTPUT_LINE_ONE_VAL], REMOTE_GPO_VAL[1]),
    line_value(gpo_cfg[LSG_GENERAL_OUTPUT_LINE_ZERO_RMT], gpo_cfg[LSG_GENERAL_OUTPUT_LINE_ZERO_VAL], REMOTE_GPO_VAL[0])};
  wire [1:0] next_oe = {gpo_cfg[LSG_GENERAL_OUTPUT_LINE_ONE_EN], gpo_cfg[LSG_GENERAL_OUTPUT_LINE_ZERO_EN]};

  always_ff @(posedge CLK) begin
    if (SRST) begin
      GPO_OUT <= 2'h0;
      GPO_OE <= 2'h0;
    end else begin
      GPO_OUT <= next_gpo;
      GPO_OE <= next_oe;
    end
  end

  // Alias decoder
  lsg_alias_if alias_bus ();
  assign alias_bus.alias_id = alias_id;
  assign alias_bus.phys_id = phys_id;
  assign alias_bus.req = I2C_REQ;
  assign alias_bus.req_addr = I2C_ADDR;
  assign FWD_REMOTE = alias_bus.fwd;
  assign FWD_BLOCKED = alias_bus.blocked;
  assign FWD_ADDR = alias_bus.fwd_addr;

  lsg_alias_dec u_alias (
    .clk(CLK),
    .srst(SRST),
    .bus(alias_bus.dec)
  );

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  sequence alias_hit_s;
    I2C_REQ && (alias_id != 7'h00) && (I2C_ADDR == alias_id);
  endsequence

  sequence built_in_self_test_steady_s;
    BUILT_IN_SELF_TEST_CRC_ERR [*3];
  endsequence

  sequence pclk_gone_s;
    !PCLK_DETECT [*3];
  endsequence

  sequence link_good_s;
    (LINK_PRESENT && (CABLE_FAULT == 4'h0)) [*3];
  endsequence

  alias_forward_a: assert property (alias_hit_s ##0 (phys_id != 7'h00) |=> FWD_REMOTE && FWD_ADDR == $past(phys_id))
    else $error("Alias hit not forwarded with physical address");
  alias_miss_a: assert property (I2C_REQ && (I2C_ADDR != alias_id) |=> !FWD_REMOTE && !FWD_BLOCKED)
    else $error("Forwarded without alias match");
  alias_zero_a: assert property ((alias_id == 7'h00) |=> !FWD_REMOTE)
    else $error("Forwarded while alias is zero");
  phys_block_a: assert property (alias_hit_s ##0 (phys_id == 7'h00) |=> FWD_BLOCKED && !FWD_REMOTE)
    else $error("Zero physical address not blocked");
  count_step_a: assert property (BC_CRC_ERR && !CRC_ERR_RESET && !cnt_full |=> err_count == 16'($past(err_count) + 16'h0001))
    else $error("Error counter did not step");
  count_hold_a: assert property (cnt_full && !CRC_ERR_RESET |=> err_count == 16'hFFFF)
    else $error("Error counter wrapped");
  count_clear_a: assert property (CRC_ERR_RESET && !BC_CRC_ERR |=> err_count == 16'h0000)
    else $error("Error counter not cleared");
  count_read_a: assert property (REG_RD && REG_ADDR == 8'h0B |=> REG_RDATA == $past(err_count[15:8]))
    else $error("High count byte misread");
  revision_read_a: assert property (REG_RD && REG_ADDR == 8'h0C |=> REG_RDATA[7:5] == REVISION)
    else $error("Revision field wrong");
  built_in_self_test_status_a: assert property (built_in_self_test_steady_s |-> status[3])
    else $error("Self-test error not shown");
  pclk_status_a: assert property (pclk_gone_s |-> !status[2])
    else $error("Pixel clock shown while absent");
  far_set_a: assert property (FAR_CRC_ERR |=> far_err [*1] ##0 status[1])
    else $error("Far-end error not set");
  far_clear_a: assert property ((CRC_ERR_RESET || !st_link) && !FAR_CRC_ERR |=> !far_err)
    else $error("Far-end error not cleared");
  link_good_a: assert property (link_good_s |-> status[0])
    else $error("Link not shown while present");
  link_fault_a: assert property ((CABLE_FAULT != 4'h0) [*3] |-> !status[0])
    else $error("Link shown during cable fault");
  line_local_a: assert property (gpo_cfg[0] && !gpo_cfg[2] |=> GPO_OE[0] && GPO_OUT[0] == $past(gpo_cfg[3]))
    else $error("Line zero not driving local value");
  line_remote_a: assert property (gpo_cfg[6] && gpo_cfg[4] |=> GPO_OE[1] && GPO_OUT[1] == $past(REMOTE_GPO_VAL[1]))
    else $error("Line one not driving remote value");
  line_tristate_a: assert property (!gpo_cfg[4] |=> !GPO_OE[1])
    else $error("Disabled line still driven");
  reset_config_a: assert property ($past(SRST) |-> gpo_cfg == 8'h55 && alias_id == 7'h00)
    else $error("Configuration reset value wrong");

  // Status pins need three steady samples, two for the synchroniser and one to settle
  sequence pclk_steady_s;
    PCLK_DETECT [*3];
  endsequence

  sequence built_in_self_test_quiet_s;
    !BUILT_IN_SELF_TEST_CRC_ERR [*3];
  endsequence

  sequence link_gone_s;
    !LINK_PRESENT [*3];
  endsequence

  // Alias decoder and its registers
  alias_write_a: assert property (REG_WR && REG_ADDR == LSG_OFS_ALIAS |=> alias_id == $past(REG_WDATA[7:1]))
    else $error("Alias field not written");

  alias_read_a: assert property (REG_RD && REG_ADDR == LSG_OFS_ALIAS |=> REG_RDATA == {$past(alias_id), 1'h0})
    else $error("Alias field misread");

  fwd_no_req_a: assert property (!I2C_REQ |=> !FWD_REMOTE && !FWD_BLOCKED)
    else $error("Forward pulse without request");

  phys_write_a: assert property (REG_WR && REG_ADDR == LSG_OFS_PHYS |=> phys_id == $past(REG_WDATA[7:1]))
    else $error("Physical address not written");

  phys_read_a: assert property (REG_RD && REG_ADDR == LSG_OFS_PHYS |=> REG_RDATA == {$past(phys_id), 1'h0})
    else $error("Physical address misread");

  fwd_addr_hold_a: assert property (!FWD_REMOTE |-> $stable(FWD_ADDR))
    else $error("Forward address moved without a forward");

  alias_zero_blk_a: assert property ((alias_id == 7'h00) |=> !FWD_BLOCKED)
    else $error("Blocked pulse while alias is zero");

  fwd_exclusive_a: assert property (!(FWD_REMOTE && FWD_BLOCKED))
    else $error("Forward and block pulses together");

  blocked_addr_a: assert property (FWD_BLOCKED |-> $stable(FWD_ADDR))
    else $error("Forward address moved on a blocked hit");

  // Error counter; clear and count in one cycle must leave one count
  count_idle_a: assert property (!BC_CRC_ERR && !CRC_ERR_RESET |=> err_count == $past(err_count))
    else $error("Error counter moved without an error");

  count_low_read_a: assert property (REG_RD && REG_ADDR == LSG_OFS_CNT_LO |=> REG_RDATA == $past(err_count[7:0]))
    else $error("Low count byte misread");

  count_set_wins_a: assert property (CRC_ERR_RESET && BC_CRC_ERR |=> err_count == 16'h0001)
    else $error("Error lost in the clearing cycle");

  count_reset_a: assert property ($past(SRST) |-> err_count == 16'h0000 && !far_err)
    else $error("Counter or far-end bit not reset");

  rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("Read data changed without a read");

  unmapped_read_a: assert property (REG_RD && REG_ADDR > LSG_OFS_GPO |=> REG_RDATA == 8'h00)
    else $error("Unmapped offset read not zero");

  // Status register
  status_read_a: assert property (REG_RD && REG_ADDR == LSG_OFS_STATUS |=> REG_RDATA[4:0] == $past(status[4:0]))
    else $error("Status low bits misread");

  pclk_seen_a: assert property (pclk_steady_s |-> status[2])
    else $error("Pixel clock not shown while present");

  built_in_self_test_clear_a: assert property (built_in_self_test_quiet_s |-> !status[3])
    else $error("Self-test error shown without errors");

  link_absent_a: assert property (link_gone_s |-> !status[0])
    else $error("Link shown while absent");

  far_hold_a: assert property (far_err && !FAR_CRC_ERR && !CRC_ERR_RESET && st_link |=> far_err)
    else $error("Far-end error dropped on its own");

  far_link_a: assert property (link_gone_s ##1 !FAR_CRC_ERR [*3] |=> !status[1])
    else $error("Far-end error kept after link loss");

  // Output lines
  line0_remote_a: assert property (gpo_cfg[2] && gpo_cfg[0] |=> GPO_OE[0] && GPO_OUT[0] == $past(REMOTE_GPO_VAL[0]))
    else $error("Line zero not driving remote value");

  line1_local_a: assert property (gpo_cfg[4] && !gpo_cfg[6] |=> GPO_OE[1] && GPO_OUT[1] == $past(gpo_cfg[7]))
    else $error("Line one not driving local value");

  line0_tristate_a: assert property (!gpo_cfg[0] |=> !GPO_OE[0])
    else $error("Disabled line zero still driven");

  gpo_write_a: assert property (REG_WR && REG_ADDR == LSG_OFS_GPO |=> gpo_cfg == ($past(REG_WDATA) & LSG_GPO_WMASK))
    else $error("Output configuration not written");

  gpo_read_a: assert property (REG_RD && REG_ADDR == LSG_OFS_GPO |=> REG_RDATA == $past(gpo_cfg))
    else $error("Output configuration misread");

  // Reserved bits must never latch a one, whatever software writes
  reserved_bits_a: assert property ((gpo_cfg & ~LSG_GPO_WMASK) == 8'h00)
    else $error("Reserved configuration bit set");

  reset_outputs_a: assert property ($past(SRST) |-> GPO_OE == 2'h0 && GPO_OUT == 2'h0 && !FWD_REMOTE)
    else $error("Outputs not quiet after reset");

  // The enable follows the register one cycle late, so a write settles before the pin moves
  line_enable_a: assert property (gpo_cfg[4] && gpo_cfg[0] |=> GPO_OE == 2'h3)
    else $error("Enabled lines not driven");
endmodule
`default_nettype wire

// ===== sim/lsg_far_model.sv
// Far-side model: remote deserializer output values and back-channel errors.
// Assumes the bench calls its tasks from one process, on falling edges.
`timescale 1ns/1ps
`default_nettype none
module lsg_far_model (
  input wire logic clk,
  output logic [1:0] remote_val,
  output logic crc_err
);
  initial begin
    remote_val = 2'h0;
    crc_err = 1'b0;
  end
  // Back to back pulses, the worst case a noisy channel gives
  task automatic crc_burst(input int n);
    repeat (n) begin
      @(negedge clk) crc_err = 1'b1;
    end
    @(negedge clk) crc_err = 1'b0;
  endtask
  task automatic set_remote(input logic [1:0] v);
    @(negedge clk) remote_val = v;
  endtask
endmodule
`default_nettype wire

// ===== sim/test_link_status_gpio_regs.sv
// Self-checking bench for the link status and output-line register bank.
// Assumes the far-side model in its own file; all inputs move on falling edges.
`timescale 1ns/1ps
`default_nettype none
module test_link_status_gpio_regs;
  import lsg_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic wr = 1'b0, rd = 1'b0, req = 1'b0, fwd, blk, far = 1'b0, crst = 1'b0;
  logic lock = 1'b0, built_in_self_test = 1'b0, pclk = 1'b0, link = 1'b0, bc;
  logic [6:0] iaddr = 7'h00, faddr;
  logic [3:0] fault = 4'h0;
  logic [1:0] rval, gout, goe;
  int bad_count = 0;
  int compares = 0;
  always #5 clk = ~clk;
  lsg_far_model i_lsg_far_model (.clk(clk), .remote_val(rval), .crc_err(bc));
  lsg_regs #(.REVISION(3'h5)) i_lsg_regs (.CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .I2C_REQ(req), .I2C_ADDR(iaddr),
    .FWD_REMOTE(fwd), .FWD_BLOCKED(blk), .FWD_ADDR(faddr), .BC_CRC_ERR(bc), .FAR_CRC_ERR(far),
    .CRC_ERR_RESET(crst), .RX_LOCK(lock), .BUILT_IN_SELF_TEST_CRC_ERR(built_in_self_test), .PCLK_DETECT(pclk),
    .LINK_PRESENT(link), .CABLE_FAULT(fault), .REMOTE_GPO_VAL(rval), .GPO_OUT(gout), .GPO_OE(goe));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check($sformatf("register %h", a), exp, rdata);
  endtask
  task automatic i2c(input logic [6:0] a, input logic [1:0] exp);
    @(negedge clk);
    iaddr = a;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    check("forward pulse", {6'h00, exp}, {6'h00, fwd, blk});
  endtask
  task automatic pulse_crst();
    @(negedge clk) crst = 1'b1;
    @(negedge clk) crst = 1'b0;
  endtask
  task automatic test_reset();
    rreg(LSG_OFS_ALIAS, 8'h00);
    rreg(LSG_OFS_CNT_LO, 8'h00);
    rreg(LSG_OFS_CNT_HI, 8'h00);
    rreg(LSG_OFS_GPO, 8'h55);
    check("output enables", 8'h03, {6'h00, goe});
    rreg(8'h20, 8'h00);
    $display("test reset done");
  endtask
  task automatic test_alias();
    wreg(LSG_OFS_PHYS, 8'h46);
    wreg(LSG_OFS_ALIAS, 8'h54);
    i2c(7'h2A, 2'b10);
    check("forward address", 8'h23, {1'b0, faddr});
    i2c(7'h2B, 2'b00);
    wreg(LSG_OFS_PHYS, 8'h00);
    i2c(7'h2A, 2'b01);
    wreg(LSG_OFS_ALIAS, 8'h00);
    wreg(LSG_OFS_PHYS, 8'h46);
    // Address zero equals the cleared alias field, so a lax decoder would fire
    i2c(7'h00, 2'b00);
    $display("test alias done");
  endtask
  task automatic test_counter();
    i_lsg_far_model.crc_burst(3);
    rreg(LSG_OFS_CNT_LO, 8'h03);
    wreg(LSG_OFS_CNT_LO, 8'hFF);
    rreg(LSG_OFS_CNT_LO, 8'h03);
    pulse_crst();
    rreg(LSG_OFS_CNT_LO, 8'h00);
    fork
      i_lsg_far_model.crc_burst(1);
      pulse_crst();
    join
    rreg(LSG_OFS_CNT_LO, 8'h01);
    i_lsg_far_model.crc_burst(258);
    rreg(LSG_OFS_CNT_LO, 8'h03);
    rreg(LSG_OFS_CNT_HI, 8'h01);
    $display("test counter done");
  endtask
  task automatic test_status();
    lock = 1'b1;
    built_in_self_test = 1'b1;
    pclk = 1'b1;
    link = 1'b1;
    tk(4);
    rreg(LSG_OFS_STATUS, 8'hBD);
    built_in_self_test = 1'b0;
    pclk = 1'b0;
    far = 1'b1;
    tk(1);
    far = 1'b0;
    tk(3);
    rreg(LSG_OFS_STATUS, 8'hB3);
    pulse_crst();
    rreg(LSG_OFS_STATUS, 8'hB1);
    far = 1'b1;
    crst = 1'b1;
    tk(1);
    far = 1'b0;
    crst = 1'b0;
    tk(1);
    rreg(LSG_OFS_STATUS, 8'hB3);
    for (int i = 0; i < 4; i++) begin
      far = 1'b1;
      tk(1);
      far = 1'b0;
      fault = 4'h1 << i;
      tk(4);
      rreg(LSG_OFS_STATUS, 8'hB0);
    end
    fault = 4'h0;
    link = 1'b0;
    $display("test status done");
  endtask
  task automatic test_gpo();
    i_lsg_far_model.set_remote(2'b10);
    tk(2);
    check("line drive", 8'h0B, {4'h0, gout, goe});
    wreg(LSG_OFS_GPO, 8'h99);
    tk(1);
    check("line drive", 8'h0F, {4'h0, gout, goe});
    wreg(LSG_OFS_GPO, 8'h11);
    tk(1);
    check("line drive", 8'h03, {4'h0, gout, goe});
    wreg(LSG_OFS_GPO, 8'hCC);
    tk(1);
    check("line enables", 8'h00, {6'h00, goe});
    wreg(LSG_OFS_GPO, 8'hFF);
    rreg(LSG_OFS_GPO, 8'hDD);
    $display("test gpo done");
  endtask
  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Bounded run: a stuck sequence is cut short and counted
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("mismatch run length expected done seen timeout");
    conclude();
  end
  initial begin
    tk(6);
    srst = 1'b0;
    test_reset();
    test_alias();
    test_counter();
    test_status();
    test_gpo();
    conclude();
  end
endmodule
`default_nettype wire
